// ### hw/smc_mode_ctrl.sv
// mode, routing and equalizer selection control with wishbone registers
//
// Overview of operation
// [RL1] four-level pins resolve at 0.2, 0.5, 0.8 of supply into L, R, F, H
// [RL2] an open pin reads as two thirds of supply, the floating state
// [RL3] host input always reaches the primary line output
// [RL4] secondary line output enabled only with its select pin at L
// [RL5] host loop-back output enabled only with its select pin at L
// [RL6] enable high and signal detected gives normal operation
// [RL7] no signal gives power save; signal returning gives normal again
// [RL8] enable low forces power-down whatever the detector says
// [RL9] power save keeps detector and serial interface running
// [RL10] power-down keeps only the serial interface running
// [RL11] signal detect readable in status and as active-low flag on lock pin
// [RL12] equalizer fixed or automatic, automatic picks best of 16 presets
// [RL13] config pin H: fixed boost 0x00 at every rate
// [RL14] config pin F: automatic at 12G, 6G, 3G; fixed 0x00 at slower rates
// [RL15] config pin R: fixed boost 0x80 at every rate
// [RL16] config pin L: fixed boost 0x90 at every rate
// [RL17] register override bits replace pin-chosen adapt mode and boost
// [RL18] decoded pins and signal detect are registered before use; the interrupt edge detect compares raw signal_detect_raw with sd_q
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module smc_mode_ctrl
    import smc_pkg::*;
#(
    parameter int SETTLE_CYC = `SMC_SETTLE_CYC,
    parameter int PRESETS    = 16
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [8:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // strap pins and analog status
    input  wire smc_pin_t    loopback_route_select,
    input  wire smc_pin_t    secondary_route_select,
    input  wire smc_pin_t    input_eq_config_pin,
    input  wire logic        enable_pin,
    input  wire logic        signal_detect_raw,
    input  wire smc_rate_t   data_rate,
    input  wire logic [7:0]  eye_metric,
    // controls to the data path
    output smc_route_t       route,
    output smc_power_t       power,
    output logic             auto_boost_mode,
    output logic      [7:0]  eq_boost,
    output logic             signal_detect_flag_low,
    output logic             irq
);
    typedef enum {PWR_NORMAL, PWR_SAVE, PWR_DOWN} pwr_state_t;
    typedef enum {AD_IDLE, AD_SWEEP, AD_DONE} ad_state_t;

    function automatic smc_lvl_t decode_lvl(input smc_pin_t p);
        logic [7:0] v;
        v = p.open ? `SMC_FLOAT_CODE : p.level; // RL2
        if (v < `SMC_TH_LR) begin // RL1
            return LVL_L;
        end else if (v < `SMC_TH_RF) begin
            return LVL_R;
        end else if (v < `SMC_TH_FH) begin
            return LVL_F;
        end
        return LVL_H;
    endfunction

    // registered pin levels and detector
    smc_lvl_t   lb_lvl, sec_lvl, eq_lvl;
    logic       en_q, sd_q;
    smc_rate_t  rate_q;
    pwr_state_t pwr_state, next_pwr_state;
    // registers
    logic [31:0] ctrl, next_ctrl;
    logic [2:0]  irq_stat, next_irq_stat, irq_mask, next_irq_mask;
    logic [7:0]  preset [PRESETS];
    logic [7:0]  next_preset [PRESETS];
    logic [31:0] next_dat;
    logic        next_ack;
    // adaptation
    ad_state_t   ad_state, next_ad_state;
    logic [3:0]  ad_idx, next_ad_idx, best_idx, next_best_idx;
    logic [7:0]  best_metric, next_best_metric;
    logic [15:0] settle, next_settle;
    logic        adapt_done;
    // outputs
    smc_route_t  next_route;
    smc_power_t  next_power;
    logic        next_auto, next_flag, next_irq;
    logic [7:0]  next_boost;

    // pin and power state
    always_comb begin
        next_pwr_state = pwr_state;
        if (!en_q) begin
            next_pwr_state = PWR_DOWN; // RL8
        end else if (sd_q) begin
            next_pwr_state = PWR_NORMAL; // RL6 RL7
        end else begin
            next_pwr_state = PWR_SAVE; // RL7
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            lb_lvl    <= LVL_F;
            sec_lvl   <= LVL_F;
            eq_lvl    <= LVL_F;
            en_q      <= 1'b0;
            sd_q      <= 1'b0;
            rate_q    <= RATE_12G;
            pwr_state <= PWR_DOWN;
        end else begin
            lb_lvl    <= decode_lvl(loopback_route_select); // RL18
            sec_lvl   <= decode_lvl(secondary_route_select); // RL18
            eq_lvl    <= decode_lvl(input_eq_config_pin); // RL18
            en_q      <= enable_pin;
            sd_q      <= signal_detect_raw; // RL18
            rate_q    <= data_rate;
            pwr_state <= next_pwr_state;
        end
    end

    // register file
    logic       acc;
    logic [6:0] idx;
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx = wb_adr_i[8:2];

    always_comb begin
        next_ctrl     = ctrl;
        next_irq_mask = irq_mask;
        next_preset   = preset;
        next_dat      = 32'h0000_0000;
        next_ack      = acc;
        next_irq_stat = irq_stat;
        if (acc && wb_we_i && wb_sel_i[0]) begin
            case (idx)
                `SMC_IDX_CTRL: next_ctrl[7:0] = wb_dat_i[7:0];
                `SMC_IDX_IRQ_STAT: next_irq_stat = irq_stat & ~wb_dat_i[2:0];
                `SMC_IDX_IRQ_MASK: next_irq_mask = wb_dat_i[2:0];
                default: begin
                    if (idx >= `SMC_IDX_PRESET0 && idx <= `SMC_IDX_PRESET15) begin
                        next_preset[idx[3:0]] = wb_dat_i[7:0]; // RL12
                    end
                end
            endcase
        end
        if (acc && wb_we_i && wb_sel_i[1] && idx == `SMC_IDX_CTRL) begin
            next_ctrl[15:8] = wb_dat_i[15:8];
        end
        // events win over a same-cycle clear
        if (sd_q && !signal_detect_raw) begin
            next_irq_stat[`SMC_IRQ_SD_FALL] = 1'b1;
        end
        if (!sd_q && signal_detect_raw) begin
            next_irq_stat[`SMC_IRQ_SD_RISE] = 1'b1;
        end
        if (adapt_done) begin
            next_irq_stat[`SMC_IRQ_ADAPT] = 1'b1;
        end
        if (acc && !wb_we_i) begin
            case (idx)
                `SMC_IDX_CTRL: next_dat = {16'h0000, ctrl[15:8], 4'h0, ctrl[3:0]};
                `SMC_IDX_STATUS: next_dat = {13'h0000, ad_state == AD_SWEEP,
                    eq_lvl, sec_lvl, lb_lvl, eq_boost, auto_boost_mode,
                    2'(pwr_state), sd_q}; // RL11
                `SMC_IDX_IRQ_STAT: next_dat = {29'h0000_0000, irq_stat};
                `SMC_IDX_IRQ_MASK: next_dat = {29'h0000_0000, irq_mask};
                default: begin
                    if (idx >= `SMC_IDX_PRESET0 && idx <= `SMC_IDX_PRESET15) begin
                        next_dat = {24'h00_0000, preset[idx[3:0]]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl     <= `SMC_CTRL_RST;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            for (int i = 0; i < PRESETS; i++) begin
                preset[i] <= {4'(i), 4'h0};
            end
        end else begin
            ctrl     <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
            preset   <= next_preset;
        end
    end

    // automatic boost sweep: try each preset, keep the best eye metric
    logic run_adapt;
    assign run_adapt = next_auto && pwr_state == PWR_NORMAL;

    always_comb begin
        next_ad_state    = ad_state;
        next_ad_idx      = ad_idx;
        next_best_idx    = best_idx;
        next_best_metric = best_metric;
        next_settle      = settle;
        adapt_done       = 1'b0;
        case (ad_state)
            AD_IDLE: begin
                if (run_adapt) begin
                    next_ad_state    = AD_SWEEP;
                    next_ad_idx      = 4'h0;
                    next_best_idx    = 4'h0;
                    next_best_metric = 8'h00;
                    next_settle      = 16'(SETTLE_CYC);
                end
            end
            AD_SWEEP: begin
                if (!run_adapt) begin
                    next_ad_state = AD_IDLE;
                end else if (settle != 16'h0000) begin
                    next_settle = settle - 16'h0001;
                end else begin
                    if (eye_metric > best_metric) begin // RL12
                        next_best_metric = eye_metric;
                        next_best_idx    = ad_idx;
                    end
                    if (ad_idx == 4'(PRESETS - 1)) begin
                        next_ad_state = AD_DONE;
                        adapt_done    = 1'b1;
                    end else begin
                        next_ad_idx = ad_idx + 4'h1;
                        next_settle = 16'(SETTLE_CYC);
                    end
                end
            end
            AD_DONE: begin
                if (!run_adapt) begin
                    next_ad_state = AD_IDLE;
                end
            end
            default: next_ad_state = AD_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ad_state    <= AD_IDLE;
            ad_idx      <= 4'h0;
            best_idx    <= 4'h0;
            best_metric <= 8'h00;
            settle      <= 16'h0000;
        end else begin
            ad_state    <= next_ad_state;
            ad_idx      <= next_ad_idx;
            best_idx    <= next_best_idx;
            best_metric <= next_best_metric;
            settle      <= next_settle;
        end
    end

    // outputs, all registered
    always_comb begin
        next_route.primary   = 1'b1; // RL3
        next_route.secondary = sec_lvl == LVL_L; // RL4
        next_route.loopback  = lb_lvl == LVL_L; // RL5
        // serial side never sleeps so software can always reach the part
        next_power.serial_on   = 1'b1; // RL9 RL10
        next_power.detector_on = next_pwr_state != PWR_DOWN; // RL9 RL10
        next_power.core_on     = next_pwr_state == PWR_NORMAL; // RL10
        case (eq_lvl)
            LVL_H: begin
                next_auto  = 1'b0; // RL13
                next_boost = `SMC_BOOST_H;
            end
            LVL_R: begin
                next_auto  = 1'b0; // RL15
                next_boost = `SMC_BOOST_R;
            end
            LVL_L: begin
                next_auto  = 1'b0; // RL16
                next_boost = `SMC_BOOST_L;
            end
            default: begin
                next_auto  = rate_q == RATE_12G || rate_q == RATE_6G
                    || rate_q == RATE_3G; // RL14
                next_boost = `SMC_BOOST_F_SLOW;
            end
        endcase
        if (ctrl[`SMC_CTRL_MODE_OVR]) begin
            next_auto = ctrl[`SMC_CTRL_MODE_VAL]; // RL17
        end
        if (next_auto) begin
            next_boost = ad_state == AD_DONE ? preset[best_idx] : preset[ad_idx];
        end else if (ctrl[`SMC_CTRL_BST_OVR]) begin
            next_boost = ctrl[`SMC_CTRL_BST_LSB +: 8]; // RL17
        end
        // flag idles high when the lock pin is not given to signal detect
        next_flag = !(ctrl[`SMC_CTRL_LOCK_SD] && sd_q); // RL11
        next_irq  = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            route                  <= '0;
            power                  <= '0;
            auto_boost_mode        <= 1'b0;
            eq_boost               <= 8'h00;
            signal_detect_flag_low <= 1'b1;
            irq                    <= 1'b0;
        end else begin
            route                  <= next_route;
            power                  <= next_power;
            auto_boost_mode        <= next_auto;
            eq_boost               <= next_boost;
            signal_detect_flag_low <= next_flag;
            irq                    <= next_irq;
        end
    end

    // checks
    sequence s_enable_drop;
        !enable_pin ##1 1'b1;
    endsequence
    property p_lvl_bounds;
        @(posedge clock) disable iff (srst)
        !input_eq_config_pin.open && input_eq_config_pin.level < `SMC_TH_LR
            |=> eq_lvl == LVL_L;
    endproperty
    a_lvl_bounds: assert property (p_lvl_bounds) else $error("low code not L"); // RL1
    property p_float;
        @(posedge clock) disable iff (srst)
        secondary_route_select.open |=> sec_lvl == LVL_F;
    endproperty
    a_float: assert property (p_float) else $error("open pin not F"); // RL2
    logic route_pulse_ok;
    always_ff @(posedge clock) begin
        route_pulse_ok <= !srst;
    end
    property p_primary;
        @(posedge clock) disable iff (srst) route_pulse_ok |-> route.primary;
    endproperty
    a_primary: assert property (p_primary) else $error("primary off"); // RL3
    property p_secondary;
        @(posedge clock) disable iff (srst)
        sec_lvl != LVL_L |=> !route.secondary;
    endproperty
    a_secondary: assert property (p_secondary) else $error("secondary on"); // RL4
    property p_loopback;
        @(posedge clock) disable iff (srst)
        lb_lvl == LVL_L |=> route.loopback;
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback off"); // RL5
    property p_normal;
        @(posedge clock) disable iff (srst)
        en_q && sd_q |=> pwr_state == PWR_NORMAL && power.core_on;
    endproperty
    a_normal: assert property (p_normal) else $error("not normal"); // RL6
    property p_save;
        @(posedge clock) disable iff (srst)
        en_q && !sd_q |=> pwr_state == PWR_SAVE && power.detector_on
            && power.serial_on && !power.core_on;
    endproperty
    a_save: assert property (p_save) else $error("not power save"); // RL7 RL9
    property p_down;
        @(posedge clock) disable iff (srst)
        s_enable_drop |=> pwr_state == PWR_DOWN && !power.detector_on
            && !power.core_on && power.serial_on;
    endproperty
    a_down: assert property (p_down) else $error("not power down"); // RL8 RL10
    property p_flag;
        @(posedge clock) disable iff (srst)
        ctrl[`SMC_CTRL_LOCK_SD] && sd_q |=> !signal_detect_flag_low;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not low"); // RL11
    property p_fixed;
        @(posedge clock) disable iff (srst)
        eq_lvl == LVL_R && !ctrl[`SMC_CTRL_MODE_OVR] && !ctrl[`SMC_CTRL_BST_OVR]
            |=> !auto_boost_mode && eq_boost == `SMC_BOOST_R;
    endproperty
    a_fixed: assert property (p_fixed) else $error("R boost wrong"); // RL15
    property p_float_slow;
        @(posedge clock) disable iff (srst)
        eq_lvl == LVL_F && rate_q == RATE_270M && !ctrl[`SMC_CTRL_MODE_OVR]
            && !ctrl[`SMC_CTRL_BST_OVR] |=> !auto_boost_mode && eq_boost == 8'h00;
    endproperty
    a_float_slow: assert property (p_float_slow) else $error("slow F wrong"); // RL14
    property p_override;
        @(posedge clock) disable iff (srst)
        ctrl[`SMC_CTRL_MODE_OVR] |=> auto_boost_mode == $past(ctrl[`SMC_CTRL_MODE_VAL]);
    endproperty
    a_override: assert property (p_override) else $error("override ignored"); // RL17
endmodule
`default_nettype wire

// ### hw/smc_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_IDX_CTRL      7'h00
`define SMC_IDX_STATUS    7'h01
`define SMC_IDX_IRQ_STAT  7'h02
`define SMC_IDX_IRQ_MASK  7'h03
`define SMC_IDX_PRESET0   7'h40
`define SMC_IDX_PRESET15  7'h4F
`define SMC_CTRL_LOCK_SD  0
`define SMC_CTRL_MODE_OVR 1
`define SMC_CTRL_MODE_VAL 2
`define SMC_CTRL_BST_OVR  3
`define SMC_CTRL_BST_LSB  8
`define SMC_CTRL_RST      32'h0000_0000
`define SMC_IRQ_SD_RISE   0
`define SMC_IRQ_SD_FALL   1
`define SMC_IRQ_ADAPT     2
`define SMC_TH_LR         8'h33
`define SMC_TH_RF         8'h80
`define SMC_TH_FH         8'hCC
`define SMC_FLOAT_CODE    8'hAA
`define SMC_BOOST_H       8'h00
`define SMC_BOOST_F_SLOW  8'h00
`define SMC_BOOST_R       8'h80
`define SMC_BOOST_L       8'h90
`define SMC_CLK_PERIOD_NS 20
`define SMC_SETTLE_NS     1000
`define SMC_SETTLE_CYC ((`SMC_SETTLE_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`endif

// ### hw/smc_pkg.sv
// types shared by the mode control block
package smc_pkg;
    typedef enum logic [1:0] {LVL_L, LVL_R, LVL_F, LVL_H} smc_lvl_t;
    typedef enum logic [2:0] {
        RATE_12G, RATE_6G, RATE_3G, RATE_1G5, RATE_270M
    } smc_rate_t;
    typedef struct packed {
        logic       open;
        logic [7:0] level;
    } smc_pin_t;
    typedef struct packed {
        logic primary;
        logic secondary;
        logic loopback;
    } smc_route_t;
    typedef struct packed {
        logic detector_on;
        logic serial_on;
        logic core_on;
    } smc_power_t;
endpackage

// ### test/smc_strap_model.sv
// strap resistor network and input channel seen by the mode control block
`timescale 1ns/1ps
`default_nettype none
module smc_strap_model
    import smc_pkg::*;
(
    // strap choices per pin
    input  wire smc_lvl_t   lb_sel,
    input  wire smc_lvl_t   sec_sel,
    input  wire smc_lvl_t   eq_sel,
    // raw voltage on the equalizer pin for threshold probing
    input  wire logic       eq_raw,
    input  wire logic [7:0] eq_volts,
    // channel feedback
    input  wire logic [7:0] eq_boost,
    output logic      [7:0] eye_metric,
    // pins
    output smc_pin_t        lb_pin,
    output smc_pin_t        sec_pin,
    output smc_pin_t        eq_pin
);
    // open pin shows a level that would decode as L, so a decoder that ignores open is caught
    function automatic smc_pin_t strap(smc_lvl_t s);
        case (s)
            LVL_L:   strap = {1'b0, 8'h00};
            LVL_R:   strap = {1'b0, 8'h55};
            LVL_F:   strap = {1'b1, 8'h00};
            default: strap = {1'b0, 8'hFF};
        endcase
    endfunction

    assign lb_pin  = strap(lb_sel);
    assign sec_pin = strap(sec_sel);
    assign eq_pin  = eq_raw ? {1'b0, eq_volts} : strap(eq_sel);
    // only one preset opens the eye, so the sweep result is unambiguous
    assign eye_metric = (eq_boost == 8'h50) ? 8'hF0 : 8'h10;
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking testbench for the mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import smc_pkg::*;
;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [8:0]  wb_adr = 9'h000;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] rd_o;
    logic        ack;
    smc_lvl_t    lb_sel = LVL_H;
    smc_lvl_t    sec_sel = LVL_H;
    smc_lvl_t    eq_sel = LVL_H;
    logic        eq_raw = 1'b0;
    logic [7:0]  eq_volts = 8'h00;
    logic        enable_pin = 1'b0;
    logic        sd = 1'b0;
    smc_rate_t   rate = RATE_1G5;
    smc_pin_t    lb_pin;
    smc_pin_t    sec_pin;
    smc_pin_t    eq_pin;
    smc_route_t  route;
    smc_power_t  power;
    logic        auto_m;
    logic [7:0]  boost;
    logic [7:0]  eye;
    logic        flag_low;
    logic        irq;
    logic [31:0] q;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc_cnt = 0;
    logic [7:0]  tv [6] = '{8'h32, 8'h33, 8'h7F, 8'h80, 8'hCB, 8'hCC};
    logic [1:0]  tl [6] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd3};
    logic [7:0]  tb [6] = '{8'h90, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};

    smc_mode_ctrl #(.SETTLE_CYC(2), .PRESETS(16)) u_dut (
        .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(rd_o),
        .wb_ack_o(ack), .loopback_route_select(lb_pin), .secondary_route_select(sec_pin),
        .input_eq_config_pin(eq_pin), .enable_pin(enable_pin), .signal_detect_raw(sd),
        .data_rate(rate), .eye_metric(eye), .route(route), .power(power),
        .auto_boost_mode(auto_m), .eq_boost(boost), .signal_detect_flag_low(flag_low), .irq(irq)
    );

    smc_strap_model u_straps (
        .lb_sel(lb_sel), .sec_sel(sec_sel), .eq_sel(eq_sel), .eq_raw(eq_raw),
        .eq_volts(eq_volts), .eq_boost(boost), .eye_metric(eye),
        .lb_pin(lb_pin), .sec_pin(sec_pin), .eq_pin(eq_pin)
    );

    always #10 clock = ~clock;

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // a hang anywhere ends up in the closing report
    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask

    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic [8:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) error_cnt++;
        q = rd_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a);
        wb(a, 1'b0, 32'h0);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    initial begin
        int n;
        wt(8);
        srst <= 1'b0;
        wt(4);
        rd(9'h000); chk(q, 32'h0);
        rd(9'h00C); chk(q, 32'h0);
        rd(9'h13C); chk(q, 32'hF0);
        rd(9'h104); chk(q, 32'h10);
        wb(9'h108, 1'b1, 32'h2B);
        rd(9'h108); chk(q, 32'h2B);
        wb(9'h010, 1'b1, 32'hFFFF_FFFF);
        rd(9'h010); chk(q, 32'h0);
        chk(32'(power), 32'h2);
        done("registers");
        // threshold probing on the equalizer pin, enable low keeps the sweep idle
        eq_raw <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            eq_volts <= tv[i];
            wt(4);
            rd(9'h004); chk(32'(q[17:16]), 32'(tl[i]));
            chk(32'(boost), 32'(tb[i]));
            chk(32'(auto_m), 32'h0);
        end
        eq_raw <= 1'b0;
        eq_sel <= LVL_F;
        wt(4);
        rd(9'h004); chk(32'(q[17:16]), 32'h2);
        done("thresholds");
        for (int i = 0; i < 16; i++) begin
            lb_sel  <= smc_lvl_t'(i[1:0]);
            sec_sel <= smc_lvl_t'(i[3:2]);
            wt(4);
            chk(32'(route), 32'({1'b1, i[3:2] == 2'd0, i[1:0] == 2'd0}));
        end
        done("routes");
        eq_sel <= LVL_H;
        enable_pin <= 1'b1;
        sd <= 1'b1;
        wt(5);
        chk(32'(power), 32'h7);
        rd(9'h004); chk(32'(q[2:1]), 32'h0);
        sd <= 1'b0;
        wt(5);
        chk(32'(power), 32'h6);
        rd(9'h004); chk(32'(q[2:1]), 32'h1);
        sd <= 1'b1;
        wt(5);
        chk(32'(power), 32'h7);
        enable_pin <= 1'b0;
        wt(5);
        chk(32'(power), 32'h2);
        sd <= 1'b0;
        wt(3);
        sd <= 1'b1;
        wt(5);
        chk(32'(power), 32'h2);
        rd(9'h004); chk(32'(q[2:1]), 32'h2);
        done("power");
        enable_pin <= 1'b1;
        sd <= 1'b0;
        wt(5);
        wb(9'h000, 1'b1, 32'h1);
        wb(9'h008, 1'b1, 32'h7);
        wb(9'h00C, 1'b1, 32'h1);
        wt(2);
        chk(32'(flag_low), 32'h1);
        chk(32'(irq), 32'h0);
        sd <= 1'b1;
        wt(5);
        chk(32'(flag_low), 32'h0);
        chk(32'(irq), 32'h1);
        rd(9'h004); chk(32'(q[0]), 32'h1);
        rd(9'h008); chk(32'(q[1:0]), 32'h1);
        wb(9'h008, 1'b1, 32'h1);
        wt(2);
        chk(32'(irq), 32'h0);
        sd <= 1'b0;
        wt(5);
        chk(32'(irq), 32'h0);
        wb(9'h00C, 1'b1, 32'h2);
        wt(2);
        chk(32'(irq), 32'h1);
        wb(9'h008, 1'b1, 32'h2);
        wb(9'h000, 1'b1, 32'h0);
        sd <= 1'b1;
        wt(4);
        chk(32'(irq), 32'h0);
        chk(32'(flag_low), 32'h1);
        done("detect");
        wb(9'h008, 1'b1, 32'h7);
        wb(9'h00C, 1'b1, 32'h4);
        rate <= RATE_12G;
        eq_sel <= LVL_F;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
        chk(32'(irq), 32'h1);
        // winning preset reaches the boost output one edge after the done flag
        wt(2);
        chk(32'(boost), 32'h50);
        chk(32'(auto_m), 32'h1);
        for (int r = 0; r < 5; r++) begin
            rate <= smc_rate_t'(r);
            wt(4);
            chk(32'(auto_m), 32'(r < 3));
            if (r >= 3) chk(32'(boost), 32'h0);
        end
        done("sweep");
        rate <= RATE_12G;
        wb(9'h000, 1'b1, 32'h370A);
        wt(4);
        chk(32'(auto_m), 32'h0);
        chk(32'(boost), 32'h37);
        eq_sel <= LVL_H;
        wb(9'h000, 1'b1, 32'h6);
        wt(4);
        chk(32'(auto_m), 32'h1);
        wb(9'h000, 1'b1, 32'h0);
        wt(4);
        chk(32'(auto_m), 32'h0);
        chk(32'(boost), 32'h0);
        done("override");
        tally_and_finish();
    end
endmodule
`default_nettype wire
